// File: core/asp_host.sv
// Purpose: Host controller that runs reads and writes on a 32K x 8 static memory
// Assumes: Memory pins wired directly, data pins resolved outside from data_pins_oe
// Notes: One access at a time; chip select rests high between accesses
//
// Contract
// RULE_01 - Memory holds 32768 bytes, 15-bit address
// RULE_02 - Memory static, host gives no refresh
// RULE_03 - Select and output enable low reads
// RULE_04 - Both enables high floats data pins
// RULE_05 - Select and write low writes, pins input
// RULE_06 - Select held low, write strobe pulsed
// RULE_07 - Select and write strobe pulsed together
// RULE_08 - Byte captured at ending rising edge
// RULE_09 - Memory never drives with select high
// RULE_10 - Select high puts memory in standby
// RULE_11 - Write strobe high during whole read
// RULE_12 - Select-ended write keeps memory outputs floating
// RULE_13 - Strobe-ended write floats with output enable high
`timescale 1ns/1ps
module asp_host (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire asp_pkg::asp_req_t req_i,
    output logic rsp_valid_o,
    output logic rsp_write_o,
    output logic [asp_pkg::DATA_W-1:0] rsp_rdata_o,
    output asp_pkg::asp_pins_t sram_o,
    input wire logic [asp_pkg::DATA_W-1:0] sram_data_pins_i
);
    import asp_pkg::*;

    // ==========================================================
    // Data pin synchroniser
    // The memory answers with no clock, so its byte is foreign to clk_i
    logic [DATA_W-1:0] dq_meta_r;
    logic [DATA_W-1:0] dq_sync_r;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dq_meta_r <= DATA_RST;
            dq_sync_r <= DATA_RST;
        end else begin
            dq_meta_r <= sram_data_pins_i;
            dq_sync_r <= dq_meta_r;
        end
    end

    // ==========================================================
    // Phase timer
    logic tmr_load;
    logic [CNT_W-1:0] tmr_val;
    logic tmr_done;

    asp_timer u_timer (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(tmr_load),
        .load_val_i(tmr_val),
        .done_o(tmr_done)
    );

    // ==========================================================
    // Access sequencer state
    asp_state_t state_r;
    asp_state_t state_nxt;
    asp_pins_t pins_r;
    asp_pins_t pins_nxt;
    logic cs_ctrl_r;
    logic cs_ctrl_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    logic rsp_write_r;
    logic rsp_write_nxt;

    // Standby pin levels: select high, no strobes, bus released
    function automatic asp_pins_t standby_pins(input logic [ADDR_W-1:0] addr);
        asp_pins_t p;
        p.address_inputs = addr;
        p.cs_n = 1'b1;
        p.oe_n = 1'b1;
        p.we_n = 1'b1;
        p.data_pins = DATA_RST;
        p.data_pins_oe = 1'b0;
        return p;
    endfunction : standby_pins

    assign req_ready_o = (state_r == ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        pins_nxt = pins_r;
        cs_ctrl_nxt = cs_ctrl_r;
        rdata_nxt = rdata_r;
        rsp_valid_nxt = 1'b0;
        rsp_write_nxt = rsp_write_r;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (state_r)
            ST_IDLE: begin
                // Select stays high while idle, so the memory rests in standby
                pins_nxt = standby_pins(pins_r.address_inputs); // RULE_10
                if (req_valid_i) begin
                    // Full 15-bit address reaches every word of the array
                    pins_nxt.address_inputs = req_i.addr; // RULE_01
                    cs_ctrl_nxt = req_i.cs_ctrl;
                    if (req_i.write) begin
                        // Address settles one cycle before the write strobe falls
                        pins_nxt.data_pins = req_i.wdata;
                        pins_nxt.data_pins_oe = 1'b1;
                        // Strobe-ended write: select goes low ahead of the pulse
                        pins_nxt.cs_n = req_i.cs_ctrl; // RULE_06
                        state_nxt = ST_WR_SETUP;
                    end else begin
                        pins_nxt.cs_n = 1'b0; // RULE_03
                        pins_nxt.oe_n = 1'b0; // RULE_03
                        pins_nxt.we_n = 1'b1; // RULE_11
                        tmr_load = 1'b1;
                        tmr_val = RD_LOAD;
                        state_nxt = ST_RD_WAIT;
                    end
                end
            end
            ST_RD_WAIT: begin
                // Write strobe held high for the full read
                pins_nxt.we_n = 1'b1; // RULE_11
                if (tmr_done) begin
                    rdata_nxt = dq_sync_r;
                    rsp_valid_nxt = 1'b1;
                    rsp_write_nxt = 1'b0;
                    // Raising select and output enable makes the memory float
                    pins_nxt.cs_n = 1'b1; // RULE_09
                    pins_nxt.oe_n = 1'b1; // RULE_09
                    // Wait out the output float time before anyone drives
                    tmr_load = 1'b1;
                    tmr_val = RD_REC_LOAD;
                    state_nxt = ST_RECOV;
                end
            end
            ST_WR_SETUP: begin
                // Output enable held high, so the memory cannot fight the host
                pins_nxt.oe_n = 1'b1; // RULE_13
                pins_nxt.we_n = 1'b0; // RULE_05
                // Combined write: select falls together with the strobe
                pins_nxt.cs_n = 1'b0; // RULE_07
                tmr_load = 1'b1;
                tmr_val = PULSE_LOAD;
                state_nxt = ST_WR_PULSE;
            end
            ST_WR_PULSE: begin
                if (tmr_done) begin
                    // The rising edge that ends the write latches the byte
                    pins_nxt.we_n = 1'b1; // RULE_08
                    pins_nxt.cs_n = ~cs_ctrl_r ? 1'b0 : 1'b1; // RULE_08
                    tmr_load = 1'b1;
                    tmr_val = HOLD_LOAD;
                    state_nxt = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                // Address and data held past the ending edge for hold time
                if (tmr_done) begin
                    pins_nxt = standby_pins(pins_r.address_inputs); // RULE_10
                    rsp_valid_nxt = 1'b1;
                    rsp_write_nxt = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = WR_REC_LOAD;
                    state_nxt = ST_RECOV;
                end
            end
            ST_RECOV: begin
                // Pads a write out to the minimum cycle time; after a read, waits out the output float time
                if (tmr_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                pins_nxt = standby_pins(ADDR_RST);
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    // No refresh or keep-alive traffic: idle means the memory is left alone
    always_ff @(posedge clk_i or posedge sys_rst_i) begin // RULE_02
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            pins_r <= standby_pins(ADDR_RST);
            cs_ctrl_r <= 1'b0;
            rdata_r <= DATA_RST;
            rsp_valid_r <= 1'b0;
            rsp_write_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pins_r <= pins_nxt;
            cs_ctrl_r <= cs_ctrl_nxt;
            rdata_r <= rdata_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_write_r <= rsp_write_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // The host drives data only with output enable high, never during a read
    assign sram_o = pins_r; // RULE_04
    assign rsp_valid_o = rsp_valid_r;
    assign rsp_write_o = rsp_write_r;
    assign rsp_rdata_o = rdata_r;

endmodule : asp_host

// File: core/asp_pkg.sv
// Purpose: Shared constants and carrier types for the static memory host port
// Assumes: 200 MHz system clock, slowest speed grade of the memory
// Notes: All pin timing is rounded to whole clock cycles
package asp_pkg;

    // ==========================================================
    // Geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int DEPTH = 32768;

    // ==========================================================
    // Clock and synchroniser
    localparam int CLK_MHZ = 200;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 6;

    // ==========================================================
    // Pin timing in ns (slowest grade, so both grades are served)
    localparam int T_RC_NS = 120;
    localparam int T_ACC_NS = 120;
    localparam int T_OHZ_NS = 40;
    localparam int T_WC_NS = 120;
    localparam int T_CW_NS = 85;
    localparam int T_AW_NS = 85;
    localparam int T_WP_NS = 80;
    localparam int T_DW_NS = 50;
    localparam int T_WR_NS = 5;

    // Least times round up to whole cycles
    localparam int RC_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000;
    localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int OHZ_CYC = (T_OHZ_NS * CLK_MHZ + 999) / 1000;
    localparam int WC_CYC = (T_WC_NS * CLK_MHZ + 999) / 1000;
    localparam int CW_CYC = (T_CW_NS * CLK_MHZ + 999) / 1000;
    localparam int AW_CYC = (T_AW_NS * CLK_MHZ + 999) / 1000;
    localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int DW_CYC = (T_DW_NS * CLK_MHZ + 999) / 1000;
    localparam int WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;

    // Strobe low time must meet pulse width, select time and address valid time
    localparam int PULSE_A = (WP_CYC > CW_CYC) ? WP_CYC : CW_CYC;
    localparam int PULSE_B = (PULSE_A > AW_CYC) ? PULSE_A : AW_CYC;
    localparam int PULSE_CYC = (PULSE_B > DW_CYC) ? PULSE_B : DW_CYC;
    // Setup cycle plus pulse plus hold, the rest of the write cycle is recovery
    localparam int WR_USED = 1 + PULSE_CYC + WR_CYC;
    localparam int WR_REST = (WC_CYC > WR_USED) ? (WC_CYC - WR_USED) : 1;
    // Read wait covers access time plus the synchroniser delay
    localparam int RD_WAIT_CYC = ACC_CYC + SYNC_STAGES;
    localparam int RD_REST = (OHZ_CYC > 1) ? OHZ_CYC : 1;

    // Timer load values: a load of N-1 gives N cycles in a state
    localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_WAIT_CYC - 1);
    localparam logic [CNT_W-1:0] RD_REC_LOAD = CNT_W'(RD_REST - 1);
    localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(WR_CYC - 1);
    localparam logic [CNT_W-1:0] WR_REC_LOAD = CNT_W'(WR_REST - 1);

    // ==========================================================
    // Reset values of the pins: standby, nothing driven
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic write;
        logic cs_ctrl;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asp_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address_inputs;
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic [DATA_W-1:0] data_pins;
        logic data_pins_oe;
    } asp_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_RECOV
    } asp_state_t;

endpackage : asp_pkg

// File: core/asp_timer.sv
// Purpose: Down counter that paces each phase of a memory access
// Assumes: Loaded in the cycle a phase is entered
// Notes: done_o is high while the count stands at zero
`timescale 1ns/1ps
module asp_timer (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire logic [asp_pkg::CNT_W-1:0] load_val_i,
    output logic done_o
);
    import asp_pkg::*;

    // ==========================================================
    // Counter
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (load_i) begin
            cnt_nxt = load_val_i;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign done_o = (cnt_r == '0);

endmodule : asp_timer

// File: tb/asp_host_monitor.sv
// Purpose: Pin protocol checks for the memory host port
// Assumes: One clock, async active-high reset
// Notes: Bound to asp_host
`timescale 1ns/1ps
module asp_host_monitor (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire asp_pkg::asp_req_t req_i,
    input wire logic rsp_valid_o,
    input wire logic rsp_write_o,
    input wire asp_pkg::asp_pins_t sram_o
);
    import asp_pkg::*;
    // ==========================================================
    // Takes
    logic tw;
    logic tr;
    assign tw = req_valid_i && req_ready_o && req_i.write;
    assign tr = req_valid_i && req_ready_o && !req_i.write;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // ==========================================================
    // Pin rules
    a_read_we_high: assert property (!sram_o.cs_n && !sram_o.oe_n |-> sram_o.we_n)
        else $error("strobe low in read");
    a_oe_guard: assert property (sram_o.data_pins_oe |-> sram_o.oe_n)
        else $error("host drives with output enable low");
    a_strobe_sel: assert property (!sram_o.we_n |-> !sram_o.cs_n && sram_o.data_pins_oe)
        else $error("strobe without select or data");
    a_pulse_width: assert property ($fell(sram_o.we_n) |-> !sram_o.we_n [*8] ##1 !sram_o.we_n [*8]
        ##1 !sram_o.we_n ##1 sram_o.we_n) else $error("strobe width wrong");
    a_we_end: assert property (tw && !req_i.cs_ctrl |-> ##19 $rose(sram_o.we_n) && !sram_o.cs_n)
        else $error("strobe-ended write wrong");
    a_cs_start: assert property (tw && req_i.cs_ctrl |=> sram_o.cs_n ##1 !sram_o.cs_n && !sram_o.we_n)
        else $error("combined write start wrong");
    a_cs_end: assert property (tw && req_i.cs_ctrl |-> ##19 $rose(sram_o.cs_n) && $rose(sram_o.we_n))
        else $error("combined write end wrong");
    a_write_done: assert property (tw |-> ##20 rsp_valid_o && rsp_write_o)
        else $error("write completion late");
    a_read_seq: assert property (tr |=> (!sram_o.cs_n && !sram_o.oe_n) [*8] ##19 rsp_valid_o && !rsp_write_o)
        else $error("read sequence wrong");
    c_we_write: cover property (tw && !req_i.cs_ctrl);
    c_cs_write: cover property (tw && req_i.cs_ctrl);
    c_read: cover property (tr);
endmodule : asp_host_monitor

bind asp_host asp_host_monitor i_asp_host_monitor (.clk_i, .sys_rst_i, .req_valid_i, .req_ready_o,
    .req_i, .rsp_valid_o, .rsp_write_o, .sram_o);

// File: tb/asp_sram_model.sv
// Purpose: Behavioural 32K x 8 static memory
// Assumes: Data pins resolved by the bench
// Notes: Unwritten cells read unknown
`timescale 1ns/1ps
module asp_sram_model (
    input wire logic [asp_pkg::ADDR_W-1:0] address_inputs_i,
    input wire logic cs_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [asp_pkg::DATA_W-1:0] data_pins_i,
    output logic [asp_pkg::DATA_W-1:0] data_pins_o,
    output logic data_pins_oe_o
);
    import asp_pkg::*;
    // ==========================================================
    // Array, no clock and no refresh
    logic [DATA_W-1:0] cells [DEPTH];
    logic wr_act;
    assign wr_act = !cs_n_i && !we_n_i;
    // Drives only in read mode, so standby and writes float
    assign data_pins_oe_o = !cs_n_i && !oe_n_i && we_n_i;
    assign data_pins_o = cells[address_inputs_i];
    // Whichever strobe rises first ends the write
    always @(negedge wr_act) cells[address_inputs_i] <= data_pins_i;
endmodule : asp_sram_model

// File: tb/asp_host_tb.sv
// Purpose: Self-checking bench for asp_host
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Released pins show a toggling pattern
`timescale 1ns/1ps
module asp_host_tb;
    import asp_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    asp_req_t req_i = '0;
    logic req_ready_o, rsp_valid_o, rsp_write_o, mem_oe;
    logic [DATA_W-1:0] rsp_rdata_o, bus, mem_q, rd;
    asp_pins_t sram_o;
    int fail_count = 0, checks_done = 0, cycles = 0, lat;
    always #2.5 clk_i = ~clk_i;
    assign bus = sram_o.data_pins_oe ? sram_o.data_pins : mem_oe ? mem_q : {8{clk_i}} ^ 8'h5A;
    asp_host i_asp_host (.clk_i, .sys_rst_i, .req_valid_i, .req_ready_o, .req_i, .rsp_valid_o,
        .rsp_write_o, .rsp_rdata_o, .sram_o, .sram_data_pins_i(bus));
    asp_sram_model i_asp_sram_model (.address_inputs_i(sram_o.address_inputs), .cs_n_i(sram_o.cs_n),
        .oe_n_i(sram_o.oe_n), .we_n_i(sram_o.we_n), .data_pins_i(bus), .data_pins_o(mem_q),
        .data_pins_oe_o(mem_oe));
    // ==========================================================
    // Helpers
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    task automatic chk_b(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t %s got %h", $time, m, got);
        end
    endtask : chk_b
    task automatic chk_n(input int got, input int exp, input string m);
        checks_done++;
        if (got != exp) begin
            fail_count++;
            $display("FAIL t=%0t %s got %0d", $time, m, got);
        end
    endtask : chk_n
    // Waits for ready, then counts edges from take to completion
    task automatic access(input logic w, input logic c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        req_i = {w, c, a, d};
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1) @(posedge clk_i) #1;
        @(posedge clk_i) #1;
        req_valid_i = 1'b0;
        lat = 1;
        while (rsp_valid_o !== 1'b1 && lat < 100) begin
            @(posedge clk_i) #1;
            lat++;
        end
        rd = rsp_rdata_o;
    endtask : access
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk_b({3'h0, sram_o.cs_n, sram_o.oe_n, sram_o.we_n, sram_o.data_pins_oe, req_ready_o}, 8'h1D, "idle");
        $display("test reset done");
    endtask : t_reset
    task automatic t_we_write();
        access(1'b1, 1'b0, 15'h7FFF, 8'hA5);
        chk_n(lat, 20, "write latency");
        chk_b({7'h0, rsp_write_o}, 8'h01, "write flag");
        access(1'b0, 1'b0, 15'h7FFF, 8'h00);
        chk_n(lat, 27, "read latency");
        chk_b({7'h0, rsp_write_o}, 8'h00, "read flag");
        chk_b(rd, 8'hA5, "top byte");
        $display("test strobe write done");
    endtask : t_we_write
    task automatic t_cs_write();
        access(1'b1, 1'b1, 15'h0000, 8'h5A);
        access(1'b1, 1'b1, 15'h0001, 8'hC3);
        access(1'b0, 1'b1, 15'h0000, 8'h00);
        chk_b(rd, 8'h5A, "byte 0");
        access(1'b0, 1'b0, 15'h0001, 8'h00);
        chk_b(rd, 8'hC3, "byte 1");
        $display("test combined write done");
    endtask : t_cs_write
    task automatic t_overwrite();
        access(1'b1, 1'b0, 15'h4000, 8'h3C);
        access(1'b1, 1'b1, 15'h4000, 8'h96);
        access(1'b0, 1'b0, 15'h4000, 8'h00);
        chk_b(rd, 8'h96, "overwrite");
        $display("test overwrite done");
    endtask : t_overwrite
    task automatic t_retain();
        repeat (300) @(posedge clk_i);
        #1;
        chk_b({7'h0, mem_oe}, 8'h00, "floating in standby");
        access(1'b0, 1'b0, 15'h7FFF, 8'h00);
        chk_b(rd, 8'hA5, "retained");
        $display("test retention done");
    endtask : t_retain
    // ==========================================================
    // Run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            $display("FAIL t=%0t timeout", $time);
            final_report();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        t_reset();
        t_we_write();
        t_cs_write();
        t_overwrite();
        t_retain();
        final_report();
    end
endmodule : asp_host_tb
